// ---- bench/ccife_irq_source.sv ----
`timescale 1ns/1ps
// Interrupt source beside the core; holds its line while the request is up, until acknowledged
module ccife_irq_source
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic resetn,
  // Request from the bench, acknowledge from the core
  input  wire logic req,
  input  wire logic irq_taken,
  // Interrupt line
  output logic      irq_pin
);
  logic served_reg;

  // one entry per request
  // Served latch keeps a level request from re-entering the handler
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
      served_reg <= 1'b0;
    else if (!req)
      served_reg <= 1'b0;
    else if (irq_taken)
      served_reg <= 1'b1;

  // raised while the request is up, dropped once the core takes it
  assign irq_pin = req & ~served_reg & ~irq_taken;
endmodule : ccife_irq_source

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
module testbench
  import ccife_pkg::*;
;
  logic              mclk, resetn, instr_valid, irq_req, irq_pin, store_en;
  ccife_instr_t      instr;
  logic [DATA_W-1:0] destination_register, source_register, store_addr, store_data;
  logic [ADDR_W-1:0] program_counter, stack_top_entry, exp_pc, exp_top;
  ccife_flags_t      flags;
  logic [SP_W-1:0]   stack_depth, exp_depth;
  logic              fetch_valid, irq_taken;
  logic [DATA_W-1:0] fetch_data;
  int                failures, n_checks;

  ccife_core u_ccife_core (.mclk(mclk), .resetn(resetn), .instr_valid(instr_valid),
    .instr(instr), .destination_register(destination_register),
    .source_register(source_register), .irq_pin(irq_pin), .store_en(store_en),
    .store_addr(store_addr), .store_data(store_data), .program_counter(program_counter),
    .flags(flags), .stack_top_entry(stack_top_entry), .stack_depth(stack_depth),
    .fetch_valid(fetch_valid), .fetch_data(fetch_data), .irq_taken(irq_taken));

  ccife_irq_source u_ccife_irq_source (.mclk(mclk), .resetn(resetn), .req(irq_req),
    .irq_taken(irq_taken), .irq_pin(irq_pin));

  // Free-running 50 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  // Valid stays up between back-to-back instructions
  task automatic exec(input ccife_op_t op, input ccife_cond_t cc, input logic u,
                      input logic [9:0] t, input logic [7:0] k);
    instr_valid = 1'b1;
    instr = '{op, cc, u, t, k};
    @(posedge mclk);
    #1;
  endtask : exec

  task automatic idle;
    instr_valid = 1'b0;
    @(posedge mclk);
    #1;
  endtask : idle

  task automatic store(input logic [7:0] a, input logic [7:0] d);
    instr_valid = 1'b0;
    store_en = 1'b1;
    store_addr = a;
    store_data = d;
    @(posedge mclk);
    #1;
    store_en = 1'b0;
  endtask : store

  // Compare sets flags, then each call condition is tried on them
  task automatic call_conds;
    logic [7:0] a;
    logic [7:0] b;
    logic       c;
    logic       z;
    logic       take;
    logic [9:0] t;
    for (int k = 0; k < 3; k++)
      for (int cc = 0; cc < 5; cc++)
      begin
        a = (k == 0) ? 8'h00 : 8'h80;
        b = (k == 0) ? 8'h00 : ((k == 1) ? 8'hFF : 8'h7F);
        destination_register = a;
        source_register = cc[0] ? ~b : b;
        exec(CCIFE_OP_CMP, CCIFE_CC_ALWAYS, cc[0], 10'h000, cc[0] ? b : ~b);
        exp_pc++;
        z = (a == b);
        c = (b > a);
        chk(flags.zero, z);
        chk(flags.carry, c);
        chk(program_counter, exp_pc);
        case (cc)
          0: take = 1'b1;
          1: take = c;
          2: take = !c;
          3: take = z;
          default: take = !z;
        endcase
        // each target stands for a subroutine ending in a return
        t = 10'h155 + 10'(cc);
        exec(CCIFE_OP_CALL, ccife_cond_t'(cc), 1'b0, t, 8'h00);
        if (take)
        begin
          exp_top = exp_pc;
          exp_pc = t;
          exp_depth++;
        end
        else
          exp_pc++;
        chk(program_counter, exp_pc);
        chk(stack_top_entry, exp_top);
        chk(stack_depth, exp_depth);
        chk({flags.carry, flags.zero}, {c, z});
      end
  endtask : call_conds

  // Call to the top address, then one step wraps to zero
  task automatic pc_wrap;
    exec(CCIFE_OP_CALL, CCIFE_CC_ALWAYS, 1'b0, 10'h3FF, 8'h00);
    chk(program_counter, 10'h3FF);
    exec(CCIFE_OP_NOP, CCIFE_CC_ALWAYS, 1'b0, 10'h000, 8'h00);
    chk(program_counter, 10'h000);
    exp_top = exp_pc;
    exp_pc = 10'h000;
    exp_depth++;
  endtask : pc_wrap

  // Masked request is ignored, then an enabled one enters the vector
  task automatic irq_cases;
    exec(CCIFE_OP_EINT, CCIFE_CC_ALWAYS, 1'b0, 10'h000, 8'h00);
    exec(CCIFE_OP_DINT, CCIFE_CC_ALWAYS, 1'b0, 10'h000, 8'h00);
    exp_pc = exp_pc + 10'h002;
    chk(flags.irq_accept_flag, 1'b0);
    irq_req = 1'b1;
    repeat (6) exec(CCIFE_OP_NOP, CCIFE_CC_ALWAYS, 1'b0, 10'h000, 8'h00);
    exp_pc = exp_pc + 10'h006;
    chk(program_counter, exp_pc);
    chk(stack_depth, exp_depth);
    chk(irq_taken, 1'b0);
    // Drain the synchroniser, else a stale level fires after enabling
    irq_req = 1'b0;
    repeat (2) idle();
    // vector in place from here on
    exec(CCIFE_OP_EINT, CCIFE_CC_ALWAYS, 1'b0, 10'h000, 8'h00);
    exp_pc++;
    chk(flags.irq_accept_flag, 1'b1);
    irq_req = 1'b1;
    for (int i = 0; i < 8 && program_counter !== IRQ_VECTOR; i++)
    begin
      exec(CCIFE_OP_NOP, CCIFE_CC_ALWAYS, 1'b0, 10'h000, 8'h00);
      exp_pc++;
    end
    chk(program_counter, IRQ_VECTOR);
    chk(stack_top_entry, exp_pc);
    chk(stack_depth, exp_depth + 5'h01);
    chk(flags.irq_accept_flag, 1'b0);
    if (program_counter !== IRQ_VECTOR)
      tally_and_finish();
    for (int i = 0; i < 2 && irq_taken !== 1'b1; i++)
      idle();
    chk(irq_taken, 1'b1);
    irq_req = 1'b0;
    exp_depth++;
    exp_pc = IRQ_VECTOR;
  endtask : irq_cases

  // Upper operand bits are dropped on both store and fetch addresses
  task automatic fetch_one(input logic u, input logic [7:0] ad, input logic [7:0] d);
    source_register = u ? ~ad : ad;
    exec(CCIFE_OP_FETCH, CCIFE_CC_ALWAYS, u, 10'h000, u ? ad : ~ad);
    exp_pc++;
    chk(program_counter, exp_pc);
    for (int i = 0; i < 2 && fetch_valid !== 1'b1; i++)
      idle();
    chk(fetch_valid, 1'b1);
    chk(fetch_data, d);
    chk(flags, 3'h0);
    if (fetch_valid !== 1'b1)
      tally_and_finish();
  endtask : fetch_one

  initial
  begin
    {resetn, instr_valid, irq_req, store_en} = 4'h0;
    instr = '0;
    {destination_register, source_register, store_addr, store_data} = 32'h0;
    {failures, n_checks, exp_pc, exp_top, exp_depth} = '0;
    repeat (5) @(posedge mclk);
    #1;
    resetn = 1'b1;
    chk({program_counter, stack_depth}, 16'h0000);
    chk(flags, 3'h0);
    call_conds();
    pc_wrap();
    irq_cases();
    store(8'h3F, 8'hA5);
    fetch_one(1'b1, 8'hFF, 8'hA5);
    store(8'hC5, 8'h5A);
    fetch_one(1'b0, 8'h45, 8'h5A);
    // deep nesting fills the stack to its last level, no deeper
    for (int i = 0; i < 20; i++)
    begin
      exec(CCIFE_OP_CALL, CCIFE_CC_ALWAYS, 1'b0, 10'h200 + 10'(i), 8'h00);
      exp_top = exp_pc;
      exp_depth++;
      exp_pc = 10'h200 + 10'(i);
      chk(stack_depth, exp_depth);
      chk(stack_top_entry, exp_top);
      chk(program_counter, exp_pc);
    end
    idle();
    tally_and_finish();
  end
endmodule : testbench

// ---- logic/ccife_core.sv ----
`timescale 1ns/1ps
// Contract
// RULE_01: Call target address is ten bits wide, whole address space.
// RULE_02: Call conditions: always, carry set, carry clear, zero set, zero clear.
// RULE_03: Taken call pushes current counter and loads the target together.
// RULE_04: Untaken call leaves stack alone and advances counter by one.
// RULE_05: Call never changes zero or carry flags.
// RULE_06: Return stack holds 31 nested levels; programs nest no deeper.
// RULE_07: Every call target holds a subroutine ending in a return.
// RULE_08: Compare uses register and 8-bit register or immediate; flags only.
// RULE_09: Compare never writes the first operand register.
// RULE_10: Compare sets zero when operands equal, else clears it.
// RULE_11: Compare sets carry when second operand exceeds first, unsigned.
// RULE_12: Disable instruction clears interrupt accept flag, advances counter.
// RULE_13: Enable instruction sets interrupt accept flag, advances counter.
// RULE_14: Program places service routine at vector 3FF before enabling.
// RULE_15: Program never enables interrupts inside a service routine.
// RULE_16: Fetch uses operand bits 5..0 as the 64-entry RAM address.
// RULE_17: Fetch copies RAM byte to destination; flags kept; counter advances.
// RULE_18: Enabled interrupt: finish instruction, push counter, load 1023, clear flag. A taken call in that cycle loses its target instead.
// RULE_19: Counter increments wrap modulo the ten-bit address space.
module ccife_core
  import ccife_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              resetn,
  // Decoded instruction, one per enabled cycle
  input  wire logic              instr_valid,
  input  ccife_instr_t           instr,
  input  wire logic [DATA_W-1:0] destination_register,
  input  wire logic [DATA_W-1:0] source_register,
  // External interrupt pin
  input  wire logic              irq_pin,
  // Scratchpad store path from the rest of the core
  input  wire logic              store_en,
  input  wire logic [DATA_W-1:0] store_addr,
  input  wire logic [DATA_W-1:0] store_data,
  // Architectural state
  output logic      [ADDR_W-1:0] program_counter,
  output ccife_flags_t           flags,
  output logic      [ADDR_W-1:0] stack_top_entry,
  output logic      [SP_W-1:0]   stack_depth,
  // Fetch result
  output logic                   fetch_valid,
  output logic      [DATA_W-1:0] fetch_data,
  // Interrupt taken
  output logic                   irq_taken
);
  // Condition test on current flags
  function automatic logic cond_true(ccife_cond_t c, ccife_flags_t f);
    unique case (c)
      CCIFE_CC_ALWAYS:           cond_true = 1'b1;
      CCIFE_CC_CARRY_SET:        cond_true = f.carry;
      CCIFE_CC_CARRY_CLR:        cond_true = !f.carry;
      CCIFE_CC_ZERO_SET:         cond_true = f.zero;
      CCIFE_CC_EQUAL_UNSET_TEST: cond_true = !f.zero;
      default:                   cond_true = 1'b0;
    endcase
  endfunction : cond_true

  logic [1:0]        irq_sync_reg;
  logic [ADDR_W-1:0] stack_mem [STACK_LVL];
  logic [ADDR_W-1:0] pc_inc;
  logic [DATA_W-1:0] operand;
  logic              call_taken;
  logic              irq_go;
  logic              push;
  logic              is_op;

  // Pin passes two flops before use
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_sync_reg <= 2'b00;
    end
    else
    begin
      irq_sync_reg <= {irq_sync_reg[0], irq_pin};
    end
  end

  // RULE_19: wrapping increment
  assign pc_inc  = program_counter + PC_STEP;
  // RULE_08: register or immediate operand
  assign operand = instr.use_imm ? instr.immediate_byte : source_register;
  // RULE_02: condition against current flags
  assign call_taken = instr_valid && instr.op == CCIFE_OP_CALL && cond_true(instr.cond, flags);
  // RULE_18: interrupt in the cycle of the current instruction; it wins over a taken call
  assign irq_go  = instr_valid && flags.irq_accept_flag && irq_sync_reg[1];
  assign push    = call_taken || irq_go;
  assign is_op   = instr_valid;

  // Program counter
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      program_counter <= PC_RESET;
    end
    else if (irq_go)
    begin
      // RULE_18: vector to highest address
      program_counter <= IRQ_VECTOR;
    end
    else if (call_taken)
    begin
      // RULE_01: full ten-bit target
      program_counter <= instr.target;
    end
    else if (is_op)
    begin
      // RULE_04: step to next instruction
      program_counter <= pc_inc;
    end
  end

  // Return stack; overflow beyond 31 levels is the program's fault
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      stack_depth <= SP_RESET;
    end
    else if (push && stack_depth != SP_W'(STACK_LVL))
    begin
      // RULE_06: depth limited to 31 levels
      stack_depth <= stack_depth + SP_STEP;
    end
  end

  // RULE_03: push current counter; interrupt pushes the resume address
  always_ff @(posedge mclk)
  begin
    if (push && stack_depth != SP_W'(STACK_LVL))
    begin
      stack_mem[stack_depth] <= irq_go ? pc_inc : program_counter;
    end
  end

  // Visible top of stack, registered; a dropped push leaves it alone
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      stack_top_entry <= PC_RESET;
    end
    else if (push && stack_depth != SP_W'(STACK_LVL))
    begin
      stack_top_entry <= irq_go ? pc_inc : program_counter;
    end
  end

  // Flags; call and fetch leave carry and zero alone
  // RULE_05: call keeps flags
  // RULE_09: no operand write-back path
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      flags <= '0;
    end
    else if (is_op)
    begin
      if (instr.op == CCIFE_OP_CMP)
      begin
        // RULE_11: unsigned greater-than sets carry
        flags.carry <= operand > destination_register;
        // RULE_10: equality sets zero
        flags.zero  <= operand == destination_register;
      end
      // RULE_12: disable clears accept flag
      if (instr.op == CCIFE_OP_DINT)
      begin
        flags.irq_accept_flag <= 1'b0;
      end
      // RULE_13: enable sets accept flag
      if (instr.op == CCIFE_OP_EINT)
      begin
        flags.irq_accept_flag <= 1'b1;
      end
      // RULE_18: accepting the interrupt clears the flag
      if (irq_go)
      begin
        flags.irq_accept_flag <= 1'b0;
      end
    end
  end

  // Interrupt acknowledge pulse
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_taken <= 1'b0;
    end
    else
    begin
      irq_taken <= irq_go;
    end
  end

  // Fetch result valid one cycle later with RAM read data
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      fetch_valid <= 1'b0;
    end
    else
    begin
      // RULE_17: copy byte to destination, flags untouched
      fetch_valid <= is_op && instr.op == CCIFE_OP_FETCH;
    end
  end

  // RULE_16: only the low six address bits reach the RAM
  ccife_scratch_ram u_ram (
    .mclk    (mclk),
    .wr_en   (store_en),
    .wr_addr (store_addr[RAM_AW-1:0]),
    .wr_data (store_data),
    .rd_addr (operand[RAM_AW-1:0]),
    .rd_data (fetch_data)
  );

  // Taken call loads target next cycle
  call_target_a: assert property (@(posedge mclk) disable iff (!resetn)
    call_taken && !irq_go |=> program_counter == $past(instr.target)) // RULE_03
    else $error("taken call did not load target");

  // Untaken call steps by one
  call_skip_a: assert property (@(posedge mclk) disable iff (!resetn)
    instr_valid && instr.op == CCIFE_OP_CALL && !call_taken && !irq_go
    |=> program_counter == $past(pc_inc) && $stable(stack_depth)) // RULE_04
    else $error("untaken call moved stack or counter wrongly");

  // Call keeps flags
  call_flags_a: assert property (@(posedge mclk) disable iff (!resetn)
    instr_valid && instr.op == CCIFE_OP_CALL |=> $stable(flags.carry) && $stable(flags.zero)) // RULE_05
    else $error("call altered flags");

  // Compare zero flag
  cmp_zero_a: assert property (@(posedge mclk) disable iff (!resetn)
    instr_valid && instr.op == CCIFE_OP_CMP
    |=> flags.zero == ($past(operand) == $past(destination_register))) // RULE_10
    else $error("compare zero flag wrong");

  // Compare carry flag
  cmp_carry_a: assert property (@(posedge mclk) disable iff (!resetn)
    instr_valid && instr.op == CCIFE_OP_CMP
    |=> flags.carry == ($past(operand) > $past(destination_register))) // RULE_11
    else $error("compare carry flag wrong");

  // Enable sets accept flag
  irq_enable_a: assert property (@(posedge mclk) disable iff (!resetn)
    instr_valid && instr.op == CCIFE_OP_EINT && !irq_go |=> flags.irq_accept_flag) // RULE_13
    else $error("enable did not set flag");

  // Disable clears accept flag
  irq_disable_a: assert property (@(posedge mclk) disable iff (!resetn)
    instr_valid && instr.op == CCIFE_OP_DINT |=> !flags.irq_accept_flag) // RULE_12
    else $error("disable did not clear flag");

  // Interrupt vectors and clears flag
  irq_vector_a: assert property (@(posedge mclk) disable iff (!resetn)
    irq_go |=> program_counter == IRQ_VECTOR && !flags.irq_accept_flag && irq_taken) // RULE_18
    else $error("interrupt entry wrong");

  // Each kept push adds one level
  stack_depth_a: assert property (@(posedge mclk) disable iff (!resetn)
    push && stack_depth != SP_W'(STACK_LVL)
    |=> stack_depth == $past(stack_depth) + SP_STEP) // RULE_06
    else $error("stack depth did not grow by one");

  // Visible top always mirrors the stored entry
  stack_top_a: assert property (@(posedge mclk) disable iff (!resetn)
    stack_depth != SP_RESET |-> stack_top_entry == stack_mem[stack_depth - SP_STEP]) // RULE_03
    else $error("stack top differs from stored entry");

  // Fetch keeps flags
  fetch_flags_a: assert property (@(posedge mclk) disable iff (!resetn)
    instr_valid && instr.op == CCIFE_OP_FETCH && !irq_go |=> $stable(flags)) // RULE_17
    else $error("fetch altered flags");
endmodule : ccife_core

// ---- logic/ccife_pkg.sv ----
package ccife_pkg;
  // Widths
  localparam int ADDR_W    = 10;
  localparam int DATA_W    = 8;
  localparam int RAM_AW    = 6;
  localparam int RAM_DEPTH = 64;
  localparam int STACK_LVL = 31;
  localparam int SP_W      = 5;
  // Reset values, fixed addresses and step sizes
  localparam logic [9:0] PC_RESET   = 10'h000;
  localparam logic [9:0] IRQ_VECTOR = 10'h3FF;
  localparam logic [9:0] PC_STEP    = 10'h001;
  localparam logic [4:0] SP_RESET   = 5'h00;
  localparam logic [4:0] SP_STEP    = 5'h01;

  // Operation selector from the instruction decoder
  typedef enum logic [2:0] {
    CCIFE_OP_NOP,
    CCIFE_OP_CALL,
    CCIFE_OP_CMP,
    CCIFE_OP_DINT,
    CCIFE_OP_EINT,
    CCIFE_OP_FETCH
  } ccife_op_t;

  // Call condition choices
  typedef enum logic [2:0] {
    CCIFE_CC_ALWAYS,
    CCIFE_CC_CARRY_SET,
    CCIFE_CC_CARRY_CLR,
    CCIFE_CC_ZERO_SET,
    CCIFE_CC_EQUAL_UNSET_TEST
  } ccife_cond_t;

  // One decoded instruction
  typedef struct packed {
    ccife_op_t   op;
    ccife_cond_t cond;
    logic        use_imm;
    logic [9:0]  target;
    logic [7:0]  immediate_byte;
  } ccife_instr_t;

  // Architectural flags
  typedef struct packed {
    logic carry;
    logic zero;
    logic irq_accept_flag;
  } ccife_flags_t;
endpackage : ccife_pkg

// ---- logic/ccife_scratch_ram.sv ----
`timescale 1ns/1ps
// 64-byte scratchpad, registered read data
module ccife_scratch_ram
  import ccife_pkg::*;
(
  // Clock
  input  wire logic              mclk,
  // Write port
  input  wire logic              wr_en,
  input  wire logic [RAM_AW-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wr_data,
  // Read port
  input  wire logic [RAM_AW-1:0] rd_addr,
  output logic      [DATA_W-1:0] rd_data
);
  logic [DATA_W-1:0] mem [RAM_DEPTH];

  // Write and registered read
  always_ff @(posedge mclk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : ccife_scratch_ram
